// [include/uart_pkg.sv]
// Constants and carrier types for the UART format, baud and transmit block.
// Assumes one 200 MHz clock and an 8-bit register port with a one-cycle read.
package uart_pkg;
   // Register offsets
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_BAUD = 3'h1;
   localparam logic [2:0] OFS_CTRL1 = 3'h2;
   localparam logic [2:0] OFS_CTRL2 = 3'h3;
   localparam logic [2:0] OFS_STATUS = 3'h4;
   // uart_control_one fields
   localparam int C1_UART_ON = 7;
   localparam int C1_NINE = 6;
   localparam int C1_PAR_ON = 5;
   localparam int C1_PAR_ODD = 4;
   localparam int C1_TWO_STOP = 3;
   localparam int C1_BREAK = 2;
   localparam int C1_RX_BIT8 = 1;
   localparam int C1_TX_BIT8 = 0;
   // uart_control_two fields
   localparam int C2_TX_ON = 7;
   localparam int C2_RX_ON = 6;
   localparam int C2_HISPEED = 5;
   localparam int C2_EMPTY_IE = 0;
   // Status fields
   localparam int ST_TXEMPTY = 0;
   localparam int ST_TXIDLE = 1;
   localparam int ST_RXIDLE = 2;
   localparam int ST_RXAVAIL = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_FRAMING = 5;
   localparam int ST_PARERR = 6;
   localparam int ST_NOISE = 7;
   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // Timing counts
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [1:0] PRE_LAST = 2'h3;
   localparam logic [3:0] BREAK_LAST = 4'hd;
   localparam logic [3:0] MIN_SLOTS = 4'h9;
   localparam logic [3:0] DATA_LAST8 = 4'h7;
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam int LOW_DIV = 64;
   localparam int HIGH_DIV = 16;

   // One register access
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : uart_pkg

// [rtl/uart_baud_format_transmitter.sv]
// UART core: baud generator, frame format, transmitter, receiver, registers.
// Assumes software on a plain one-cycle register port and a remote UART on the pins.
//
// How it works
// R1 - Transmit empty flag raises the interrupt request only while its enable is set.
// R2 - One 8-bit data location serves transmit writes and receive reads.
// R3 - Bit rate is clock over 64(N+1) in low speed, 16(N+1) in high.
// R4 - A free-running 8-bit timer reloads from the divisor N, 0 to 255.
// R5 - Frames are NRZ: start, eight or nine data slots, one or two two_stop_select.
// R6 - After reset the format is eight data bits, no parity, one stop.
// R7 - Both directions share format and baud rate and shift LSB first.
// R8 - Parity is even, odd or absent, chosen by two control bits.
// R9 - Parity sits in the last data slot, leaving seven or eight data bits.
// R10 - Stop bit count is chosen apart from the data length.
// R11 - Pins belong to the UART only when global, transmit and receive enables are set.
// R12 - The transmit line idles high.
// R13 - Global disable releases the pins and empties the buffers.
// R14 - Global disable clears transmit and receive enables, break and receive flags, sets idle and empty.
// R15 - Global disable two_stop_select traffic at once; re-enable keeps the configuration.
// R16 - The shifter reloads from the buffer only after the last stop bit.
// R17 - In nine-bit mode the ninth control bit is sent as data MSB.
// R18 - A frame starts once data is loaded, the transmitter enabled and a bit tick comes.
// R19 - A write while the shifter is empty goes straight into the shifter.
// R20 - Clearing the transmit enable aborts the frame and resets the transmitter.
// R21 - The shifter has no register address.
// R22 - Parity odd select low gives even parity, high gives odd.
// R23 - Nine bit select high gives nine data slots, low gives eight.
// R24 - Data reads return received data; writes go to the transmit buffer.
// R25 - The receiver samples at the same divisor as the transmitter.
`timescale 1ns/1ps
module uart_baud_format_transmitter import uart_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // Register port
   input wire reg_req_t req_i,
   output logic [7:0] rd_data_o,
   // Serial pins
   input wire logic rx_i,
   output logic tx_o,
   output logic tx_oe_o,
   output logic rx_owned_o,
   // Interrupt request
   output logic irq_req_o
);
   typedef enum logic [1:0] {TX_IDLE, TX_PEND, TX_SHIFT, TX_BREAK} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

   logic [7:0] ctrl1_q, ctrl2_q, baud_q, tx_buf_q, rd_q;
   logic [8:0] rx_buf_q, rx_sh_q, rx_word;
   logic [11:0] tx_shift_q, load_frame;
   logic [3:0] tx_left_q, brk_cnt_q, tx_len, os_cnt_q, rx_os_q, rx_cnt_q;
   logic [1:0] pre_q;
   logic [7:0] base_q;
   logic [2:0] rx_s_q, smp_q;
   tx_state_t tx_st_q;
   rx_state_t rx_st_q;
   logic tx_line_q, txempty_q, txidle_q, rxavail_q, overrun_q, framing_q, parerr_q;
   logic noise_q, rxidle_q, uen_prev_q, run_prev_q, rx_lvl_q, rx_noisy_q;
   logic tx_oe_q, rx_own_q, irq_q;
   logic uen, nine, par_on, par_odd, two_stop, brk, tx_on, rx_on, hispeed, empty_ie;
   logic dis_ev, tx_run, tx_abort, rx_run, base_tick, os_tick, bit_tick;
   logic wr_data, accepted, rd_data, frame_end, buf_load, direct_load;
   logic rx_done, rx_start, bit_done, maj, noisy, rx_par_bad;

   // Control fields
   assign uen = ctrl1_q[C1_UART_ON];
   assign nine = ctrl1_q[C1_NINE]; // see R23
   assign par_on = ctrl1_q[C1_PAR_ON];
   assign par_odd = ctrl1_q[C1_PAR_ODD];
   assign two_stop = ctrl1_q[C1_TWO_STOP]; // see R10
   assign brk = ctrl1_q[C1_BREAK];
   assign tx_on = ctrl2_q[C2_TX_ON];
   assign rx_on = ctrl2_q[C2_RX_ON];
   assign hispeed = ctrl2_q[C2_HISPEED];
   assign empty_ie = ctrl2_q[C2_EMPTY_IE];

   // Events of the register port and of enables
   assign dis_ev = uen_prev_q & ~uen;
   assign tx_run = uen & tx_on;
   assign rx_run = uen & rx_on;
   assign tx_abort = dis_ev | (run_prev_q & ~tx_run); // see R20
   assign wr_data = req_i.wr && (req_i.addr == OFS_DATA) && uen;
   assign accepted = wr_data & txempty_q; // Writes are refused while the buffer is full
   assign rd_data = req_i.rd && (req_i.addr == OFS_DATA);

   // Frame assembly, done once at load so format changes mid-frame do no harm
   function automatic logic [11:0] frame_of(input logic [7:0] b, input logic b8,
                                            input logic n9, input logic pe, input logic od);
      logic [8:0] w;
      logic par;
      w = n9 ? {b8, b} : {1'b0, b}; // see R17
      par = (n9 ? ^b : ^b[6:0]) ^ od; // see R22
      if (pe) begin
         if (n9) begin
            w[8] = par; // see R9
         end else begin
            w[7] = par; // see R9
         end
      end
      // Ones above the data slots become the stop bits
      frame_of = n9 ? {2'b11, w, 1'b0} : {3'b111, w[7:0], 1'b0}; // see R5
   endfunction : frame_of

   assign direct_load = (tx_st_q == TX_IDLE) & accepted; // see R19
   assign frame_end = (tx_st_q == TX_SHIFT) & bit_tick & (tx_left_q == 4'h0);
   // Buffer moves on only after the last stop slot has run its full time
   assign buf_load = ~txempty_q & (frame_end | (tx_st_q == TX_IDLE)); // see R16
   assign load_frame = frame_of(direct_load ? req_i.wdata : tx_buf_q,
                                ctrl1_q[C1_TX_BIT8], nine, par_on, par_odd); // see R8
   assign tx_len = MIN_SLOTS + {3'b000, nine} + {3'b000, two_stop}; // see R10

   // Control registers; global disable clears only its listed bits
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl1_q <= CTRL1_RST; // see R6
         ctrl2_q <= CTRL2_RST;
         baud_q <= BAUD_RST;
         uen_prev_q <= 1'b0;
         run_prev_q <= 1'b0;
      end else begin
         uen_prev_q <= uen;
         run_prev_q <= tx_run;
         if (req_i.wr && req_i.addr == OFS_CTRL1) begin
            ctrl1_q <= {req_i.wdata[7:2], 1'b0, req_i.wdata[0]};
         end
         if (req_i.wr && req_i.addr == OFS_CTRL2) begin
            ctrl2_q <= req_i.wdata;
         end
         if (req_i.wr && req_i.addr == OFS_BAUD) begin
            baud_q <= req_i.wdata; // see R4
         end
         if (dis_ev) begin
            ctrl2_q[C2_TX_ON] <= 1'b0; // see R14
            ctrl2_q[C2_RX_ON] <= 1'b0; // see R14
            ctrl1_q[C1_BREAK] <= 1'b0; // see R14
         end
      end
   end

   // Baud timer: N+1 clocks, then 4 more in low speed, then 16 per bit
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         base_q <= 8'h00;
         pre_q <= 2'h0;
         os_cnt_q <= 4'h0;
      end else if (!uen) begin
         base_q <= 8'h00; // see R15
         pre_q <= 2'h0;
         os_cnt_q <= 4'h0;
      end else begin
         base_q <= base_tick ? 8'h00 : base_q + 8'h01; // see R4
         if (base_tick) begin
            pre_q <= pre_q + 2'h1;
         end
         if (os_tick) begin
            os_cnt_q <= os_cnt_q + 4'h1;
         end
      end
   end
   assign base_tick = uen & (base_q == baud_q);
   assign os_tick = base_tick & (hispeed | (pre_q == PRE_LAST)); // see R3
   assign bit_tick = os_tick & (os_cnt_q == OS_LAST); // see R3

   // Transmit sequencer; shifter stays internal
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_st_q <= TX_IDLE;
         tx_shift_q <= 12'hfff; // see R21
         tx_left_q <= 4'h0;
         brk_cnt_q <= 4'h0;
         tx_line_q <= 1'b1;
      end else if (tx_abort) begin
         tx_st_q <= TX_IDLE; // see R20
         tx_line_q <= 1'b1;
         tx_left_q <= 4'h0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               if (direct_load || buf_load) begin
                  tx_shift_q <= load_frame;
                  tx_st_q <= TX_PEND;
               end else if (brk && tx_run && bit_tick) begin
                  tx_line_q <= 1'b0;
                  brk_cnt_q <= BREAK_LAST;
                  tx_st_q <= TX_BREAK;
               end
            end
            TX_PEND: begin
               // Waits for the enable as well, so data loaded early still goes
               if (tx_run && bit_tick) begin // see R18
                  tx_line_q <= tx_shift_q[0];
                  tx_shift_q <= {1'b1, tx_shift_q[11:1]};
                  tx_left_q <= tx_len;
                  tx_st_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (bit_tick && tx_left_q != 4'h0) begin
                  tx_line_q <= tx_shift_q[0]; // see R7
                  tx_shift_q <= {1'b1, tx_shift_q[11:1]};
                  tx_left_q <= tx_left_q - 4'h1;
               end else if (buf_load) begin
                  tx_line_q <= 1'b0; // see R16
                  tx_shift_q <= {1'b1, load_frame[11:1]};
                  tx_left_q <= tx_len;
               end else if (frame_end && brk) begin
                  tx_line_q <= 1'b0;
                  brk_cnt_q <= BREAK_LAST;
                  tx_st_q <= TX_BREAK;
               end else if (frame_end) begin
                  tx_line_q <= 1'b1; // see R12
                  tx_st_q <= TX_IDLE;
               end
            end
            TX_BREAK: begin
               if (bit_tick && brk_cnt_q != 4'h0) begin
                  brk_cnt_q <= brk_cnt_q - 4'h1;
               end else if (bit_tick && brk) begin
                  brk_cnt_q <= BREAK_LAST;
               end else if (bit_tick) begin
                  // Stop bits close the break frame
                  tx_line_q <= 1'b1;
                  tx_shift_q <= 12'hfff;
                  tx_left_q <= {3'b000, two_stop};
                  tx_st_q <= TX_SHIFT;
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
            end
         endcase
      end
   end

   // Transmit buffer holds one byte behind the shifter
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_buf_q <= DATA_RST;
      end else if (accepted && !direct_load) begin
         tx_buf_q <= req_i.wdata; // see R24
      end
   end

   // Transmit flags; set wins over clear
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txempty_q <= 1'b1;
         txidle_q <= 1'b1;
      end else if (tx_abort) begin
         txempty_q <= 1'b1; // see R13
         txidle_q <= 1'b1; // see R14
      end else begin
         if (accepted && !direct_load) begin
            txempty_q <= 1'b0;
         end
         if (accepted) begin
            txidle_q <= 1'b0;
         end
         if (buf_load) begin
            txempty_q <= 1'b1;
         end
         if (frame_end && !buf_load) begin
            txidle_q <= 1'b1;
         end
      end
   end

   // Receive pin synchroniser; a change counts when stages two and three agree
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_s_q <= 3'b111;
         rx_lvl_q <= 1'b1;
      end else begin
         rx_s_q <= {rx_s_q[1:0], rx_i};
         if (rx_s_q[1] == rx_s_q[2]) begin
            rx_lvl_q <= rx_s_q[2];
         end
      end
   end

   // Receiver at sixteen samples per bit from the shared timer
   assign bit_done = os_tick & (rx_os_q == OS_LAST); // see R25
   assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
   assign noisy = ~(&smp_q) & (|smp_q);
   assign rx_start = (rx_st_q == RX_IDLE) & rx_run & os_tick & ~rx_lvl_q;
   assign rx_done = (rx_st_q == RX_STOP) & bit_done;
   assign rx_word = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
   assign rx_par_bad = par_on & ((nine ? ^rx_word : ^rx_word[7:0]) ^ par_odd);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_st_q <= RX_IDLE;
         rx_os_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 9'h000;
         smp_q <= 3'b111;
         rx_noisy_q <= 1'b0;
      end else if (!rx_run) begin
         rx_st_q <= RX_IDLE; // see R15
      end else begin
         if (os_tick && rx_os_q >= SMP_A && rx_os_q <= SMP_C) begin
            smp_q <= {smp_q[1:0], rx_lvl_q};
         end
         if (os_tick && rx_st_q != RX_IDLE) begin
            rx_os_q <= rx_os_q + 4'h1;
         end
         if (bit_done && noisy) begin
            rx_noisy_q <= 1'b1;
         end
         case (rx_st_q)
            RX_IDLE: begin
               if (rx_start) begin
                  rx_os_q <= 4'h0;
                  rx_noisy_q <= 1'b0;
                  rx_st_q <= RX_START;
               end
            end
            RX_START: begin
               if (bit_done) begin
                  rx_cnt_q <= 4'h0;
                  rx_st_q <= maj ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (bit_done) begin
                  rx_sh_q <= {maj, rx_sh_q[8:1]}; // see R7
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q == DATA_LAST8 + {3'b000, nine}) begin
                     rx_st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (bit_done) begin
                  rx_st_q <= RX_IDLE;
               end
            end
            default: begin
               rx_st_q <= RX_IDLE;
            end
         endcase
      end
   end

   // Received word store; a full store refuses the new word
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_buf_q <= 9'h000;
      end else if (rx_done && (!rxavail_q || rd_data)) begin
         // A read in the same cycle frees the store, so the new word must land
         rx_buf_q <= rx_word; // see R24
      end
   end

   // Receive flags; a data read clears all but the idle flag, a new event in that cycle wins
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {rxavail_q, overrun_q, framing_q, parerr_q, noise_q} <= 5'b00000;
         rxidle_q <= 1'b1;
      end else if (dis_ev) begin
         {rxavail_q, overrun_q, framing_q, parerr_q, noise_q} <= 5'b00000; // see R14
         rxidle_q <= 1'b1; // see R14
      end else begin
         if (rd_data) begin
            {rxavail_q, overrun_q, framing_q, parerr_q, noise_q} <= 5'b00000;
         end
         if (rx_start) begin
            rxidle_q <= 1'b0;
         end
         if (rx_done || !rx_run) begin
            rxidle_q <= 1'b1;
         end
         if (rx_done && rxavail_q && !rd_data) begin
            overrun_q <= 1'b1;
         end else if (rx_done) begin
            rxavail_q <= 1'b1;
            framing_q <= ~maj;
            parerr_q <= rx_par_bad;
            noise_q <= rx_noisy_q | noisy;
         end
      end
   end

   // Outputs from flip-flops: pin ownership, request flag, read data
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_oe_q <= 1'b0;
         rx_own_q <= 1'b0;
         irq_q <= 1'b0;
         rd_q <= 8'h00;
      end else begin
         tx_oe_q <= uen & tx_on & rx_on; // see R11
         rx_own_q <= uen & tx_on & rx_on; // see R13
         irq_q <= empty_ie & txempty_q; // see R1
         rd_q <= 8'h00;
         if (req_i.rd) begin
            case (req_i.addr)
               OFS_DATA: rd_q <= rx_buf_q[7:0]; // see R2
               OFS_BAUD: rd_q <= baud_q;
               OFS_CTRL1: rd_q <= {ctrl1_q[7:2], rx_buf_q[8], 1'b0};
               OFS_CTRL2: rd_q <= ctrl2_q;
               OFS_STATUS: rd_q <= {noise_q, parerr_q, framing_q, overrun_q,
                                    rxavail_q, rxidle_q, txidle_q, txempty_q};
               default: rd_q <= 8'h00;
            endcase
         end
      end
   end
   assign tx_o = tx_line_q;
   assign tx_oe_o = tx_oe_q;
   assign rx_owned_o = rx_own_q;
   assign irq_req_o = irq_q;
   assign rd_data_o = rd_q;

   // Checks on the design's own behaviour
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   logic [13:0] gap_q;
   logic gap_ok_q;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap_q <= 14'h0000;
         gap_ok_q <= 1'b0;
      end else begin
         gap_q <= bit_tick ? 14'h0000 : gap_q + 14'h0001;
         if (!uen || req_i.wr) begin
            gap_ok_q <= 1'b0;
         end else if (bit_tick) begin
            gap_ok_q <= 1'b1;
         end
      end
   end

   sequence s_start_tick;
      tx_st_q == TX_PEND && tx_run && bit_tick && !tx_abort;
   endsequence
   sequence s_last_slot;
      tx_st_q == TX_SHIFT && frame_end && !tx_abort;
   endsequence

   a_irq_gate: assert property ($rose(txempty_q) && empty_ie |=> irq_req_o) // see R1
      else $error("empty flag with enable did not raise request");
   a_irq_mask: assert property (!empty_ie ##1 !empty_ie |-> !irq_req_o) // see R1
      else $error("request raised while masked");
   a_baud_period: assert property (bit_tick && gap_ok_q && !req_i.wr |->  // see R3
      32'(gap_q) + 1 == (hispeed ? HIGH_DIV : LOW_DIV) * (32'(baud_q) + 1))
      else $error("bit period differs from divisor setting");
   a_start_bit: assert property (s_start_tick |=> !tx_line_q) // see R18
      else $error("frame did not open with a start bit");
   a_lsb_order: assert property (tx_st_q == TX_SHIFT && bit_tick && tx_left_q != 4'h0
      && !tx_abort |=> tx_line_q == $past(tx_shift_q[0])) // see R7
      else $error("shift order broken");
   a_stop_high: assert property (s_last_slot |-> tx_line_q) // see R5
      else $error("last slot of a frame was not a stop bit");
   a_idle_high: assert property (tx_st_q == TX_IDLE |-> tx_line_q) // see R12
      else $error("line low while idle");
   a_disable_flags: assert property (dis_ev |=> txempty_q && txidle_q && rxidle_q
      && !rxavail_q && !overrun_q && !tx_on && !rx_on && !brk) // see R14
      else $error("disable left flags or enables wrong");
   a_pin_release: assert property (!uen |=> !tx_oe_o && !rx_owned_o) // see R13
      else $error("pins kept while disabled");
   a_tx_abort: assert property ($fell(tx_run) |-> ##[0:1] tx_st_q == TX_IDLE) // see R20
      else $error("transmitter kept running after enable fell");
   a_buf_guard: assert property (wr_data && !txempty_q |=> $stable(tx_buf_q)) // see R16
      else $error("full buffer overwritten");
   a_direct_move: assert property (direct_load && !tx_abort |=> tx_st_q == TX_PEND
      && txempty_q) // see R19
      else $error("write to empty shifter not moved at once");
endmodule : uart_baud_format_transmitter

// [tb/remote_uart.sv]
// Remote serial device model on the far side of the UART pins.
// Assumes the bench passes the bit period in clocks and calls on a rising edge.
`timescale 1ns/1ps
module remote_uart (
   // Clock
   input wire logic clock_i,
   // Serial lines
   input wire logic tx_i,
   output logic rx_o
);
   // Line idles high outside frames
   initial rx_o = 1'b1;
   // Start, n data bits LSB first, one stop
   task automatic send(input logic [8:0] d, input int n, input int per);
      rx_o <= 1'b0;
      repeat (per) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         rx_o <= d[i];
         repeat (per) @(posedge clock_i);
      end
      rx_o <= 1'b1;
      repeat (per) @(posedge clock_i);
   endtask : send
   // Mid-bit sampling keeps edge jitter out of the result
   task automatic grab(output logic [11:0] s, input int n, input int per);
      s = '0;
      @(negedge tx_i);
      repeat (per / 2) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         s[i] = tx_i;
         repeat (per) @(posedge clock_i);
      end
   endtask : grab
endmodule : remote_uart

// [tb/uart_baud_format_transmitter_bench.sv]
// Self-checking bench for the UART format, baud and transmit block.
// Assumes the remote model watches TX and drives RX.
`timescale 1ns/1ps
module uart_baud_format_transmitter_bench;
   import uart_pkg::*;
   // Design hookup
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   reg_req_t req_i = '0;
   logic [7:0] rd_data_o;
   logic rx_i, tx_o, tx_oe_o, rx_owned_o, irq_req_o;
   int bad_count = 0;
   int compares = 0;
   uart_baud_format_transmitter i_uart_baud_format_transmitter (.clock_i(clock_i),
      .rst_b_i(rst_b_i), .req_i(req_i), .rd_data_o(rd_data_o), .rx_i(rx_i), .tx_o(tx_o),
      .tx_oe_o(tx_oe_o), .rx_owned_o(rx_owned_o), .irq_req_o(irq_req_o));
   remote_uart i_remote_uart (.clock_i(clock_i), .tx_i(tx_o), .rx_o(rx_i));
   // 200 MHz clock
   initial forever #2.5 clock_i = ~clock_i;
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Trailing idle edge so the next strobe never lands in the same step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      req_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_i);
      req_i <= '0;
      @(posedge clock_i);
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      req_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_i);
      req_i <= '0;
      #1 chk(rd_data_o, e);
      @(posedge clock_i);
   endtask : rd
   task automatic frame(input logic [7:0] c1, input logic [7:0] d, input int n,
      input int per, input logic [11:0] e);
      logic [11:0] s;
      wr(OFS_CTRL1, c1);
      fork
         i_remote_uart.grab(s, n, per);
         wr(OFS_DATA, d);
      join
      chk(s, e);
   endtask : frame
   task automatic t_reset();
      rd(OFS_STATUS, 8'h07);
      rd(OFS_CTRL1, 8'h00);
      rd(3'h7, 8'h00);
      chk(tx_o, 1'b1);
      wr(OFS_BAUD, 8'h01);
      wr(OFS_CTRL2, 8'hE0);
      wr(OFS_CTRL1, 8'h80);
      // Ownership flops load on the edge the write task returns on
      @(posedge clock_i);
      chk({tx_oe_o, rx_owned_o}, 2'b11);
   endtask : t_reset
   task automatic t_rx();
      i_remote_uart.send(9'h03C, 8, 32);
      // Receiver ends a few clocks after the stop bit: sync delay plus tick phase
      repeat (12) @(posedge clock_i);
      rd(OFS_STATUS, 8'h0F);
      rd(OFS_DATA, 8'h3C);
   endtask : t_rx
   task automatic t_format();
      for (int o = 0; o < 2; o++) begin
         frame(8'hB8 & ~8'h10 | {3'h0, o[0], 4'h0}, 8'h35, 11, 32,
            {1'b0, 2'b11, (^7'h35) ^ o[0], 7'h35, 1'b0});
      end
      frame(8'hC1, 8'h5A, 11, 32, {1'b0, 1'b1, 1'b1, 8'h5A, 1'b0});
      wr(OFS_BAUD, 8'h00);
      wr(OFS_CTRL2, 8'hC0);
      frame(8'h80, 8'hC4, 10, 64, {2'b00, 1'b1, 8'hC4, 1'b0});
   endtask : t_format
   task automatic t_irq_off();
      repeat (2) @(posedge clock_i);
      chk(irq_req_o, 1'b0);
      wr(OFS_CTRL2, 8'hC1);
      @(posedge clock_i);
      chk(irq_req_o, 1'b1);
      wr(OFS_DATA, 8'h00);
      // Second byte waits in the buffer, so the empty flag and request drop
      wr(OFS_DATA, 8'h11);
      @(posedge clock_i);
      chk(irq_req_o, 1'b0);
      repeat (100) @(posedge clock_i);
      wr(OFS_CTRL1, 8'h08);
      repeat (2) @(posedge clock_i);
      chk({tx_o, tx_oe_o, irq_req_o}, 3'b101);
      rd(OFS_STATUS, 8'h07);
      rd(OFS_CTRL2, 8'h01);
      wr(OFS_DATA, 8'h77);
      rd(OFS_STATUS, 8'h07);
   endtask : t_irq_off
   task automatic final_report();
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      repeat (20) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      frame(8'h80, 8'hA3, 10, 32, {2'b00, 1'b1, 8'hA3, 1'b0});
      t_rx();
      t_format();
      t_irq_off();
      final_report();
   end
   // Runs take under 8000 cycles
   initial begin
      repeat (30000) @(posedge clock_i);
      bad_count++;
      final_report();
   end
endmodule : uart_baud_format_transmitter_bench
